// ===== logic/cutoff_input_filter.sv
// Input synchroniser with low pulse suppression
`default_nettype none

module cutoff_input_filter
   import cutoff_mon_pkg::*;
#(
   parameter int HOLD_CYC = PULSE_IGNORE_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Raw pin and filtered level
   input wire logic raw_in,
   output logic level
);

   logic meta;
   logic sync;
   logic [CNT_W-1:0] low_cnt;

   // Two flops; meta is read by sync alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         sync <= 1'b0;
      end else begin
         meta <= raw_in;
         sync <= meta;
      end
   end

   // Rise passes at once, a low must outlast HOLD_CYC cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= '0;
         level <= 1'b0;
      end else if (sync) begin
         low_cnt <= '0;
         level <= 1'b1;
      end else if (low_cnt == CNT_W'(HOLD_CYC)) begin
         level <= 1'b0;
      end else begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

endmodule

`default_nettype wire

// ===== logic/cutoff_mon_pkg.sv
// Constants and types of the dual channel torque cut-off monitor
`default_nettype none

package cutoff_mon_pkg;

   // ----------------------------------------------------------------
   // Sizes and clock
   // ----------------------------------------------------------------
   localparam int NUM_AXES = 2;
   localparam int CLK_MHZ = 125;
   localparam int CNT_W = 24;

   // ----------------------------------------------------------------
   // Times and derived cycle counts
   // ----------------------------------------------------------------
   localparam int PULSE_IGNORE_US = 1000;      // Low pulses ignored
   localparam int SIMUL_LIMIT_MS = 100;        // Channel skew allowed
   localparam int CUTOFF_DELAY_MAX_US = 2000;  // Assert and release
   localparam int RESPONSE_MAX_US = 3500;      // Torque removal
   localparam int PULSE_IGNORE_CYC = PULSE_IGNORE_US * CLK_MHZ;
   localparam int SIMUL_LIMIT_CYC = SIMUL_LIMIT_MS * 1000 * CLK_MHZ;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] CLEAR_OFS = 8'h08;
   localparam logic [7:0] CODE0_OFS = 8'h0C;
   localparam logic [7:0] CODE1_OFS = 8'h10;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] REPORT_RST = 2'h3;  // Reporting on
   localparam int STATUS_LANE = 8;            // Bits per axis
   localparam int CLR_CUT_POS = 0;            // Cut-off fault clears
   localparam int CLR_SIMUL_POS = 8;          // Simultaneity clears
   localparam int CODE_WARN_POS = 16;
   localparam int CODE_VALID_POS = 17;

   // ----------------------------------------------------------------
   // Message codes: group then identifier
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_GROUP = 8'h90;
   localparam logic [7:0] CODE_ID_CUTOFF = 8'h00;
   localparam logic [7:0] CODE_ID_SIMUL = 8'h05;

   // ----------------------------------------------------------------
   // Power section release states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PWR_HOLD = 3'b001,
      PWR_REARM = 3'b010,
      PWR_FREE = 3'b100
   } pwr_state_t;

endpackage

`default_nettype wire

// ===== logic/torque_cutoff_monitor.sv
// Dual channel torque cut-off monitor with APB register access
`default_nettype none

module torque_cutoff_monitor
   import cutoff_mon_pkg::*;
#(
   parameter int PULSE_IGNORE_CYCLES = PULSE_IGNORE_CYC,
   parameter int SIMUL_LIMIT_CYCLES = SIMUL_LIMIT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Safety inputs, one bit per axis
   input wire logic [NUM_AXES-1:0] cutoff_channel_a_input,
   input wire logic [NUM_AXES-1:0] cutoff_channel_b_input,
   input wire logic [NUM_AXES-1:0] axis_enable_input,
   // Drive outputs, one bit per axis
   output logic [NUM_AXES-1:0] torque_enable,
   output logic [NUM_AXES-1:0] power_released,
   output logic [NUM_AXES-1:0] cutoff_active
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Message word of one axis, simultaneity first
   function automatic logic [31:0] message_word(
      input logic simul,
      input logic fault,
      input logic warn
   );
      logic [31:0] w;
      w = '0;
      if (simul) begin
         w[15:0] = {CODE_GROUP, CODE_ID_SIMUL};
         w[CODE_VALID_POS] = 1'b1;
      end else if (fault || warn) begin
         w[15:0] = {CODE_GROUP, CODE_ID_CUTOFF};
         w[CODE_WARN_POS] = ~fault;
         w[CODE_VALID_POS] = 1'b1;
      end
      return w;
   endfunction

   // Offsets that answer without error
   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == CTRL_OFS) || (a == STATUS_OFS) ||
             (a == CLEAR_OFS) || (a == CODE0_OFS) ||
             (a == CODE1_OFS);
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [NUM_AXES-1:0] report_fault_setting;
   logic [NUM_AXES-1:0] channel_a_status;
   logic [NUM_AXES-1:0] channel_b_status;
   logic [NUM_AXES-1:0] cutoff_warning;
   logic [NUM_AXES-1:0] cutoff_fault;
   logic [NUM_AXES-1:0] simultaneity_fault;
   logic [NUM_AXES-1:0] clr_cut;
   logic [NUM_AXES-1:0] clr_simul;
   logic setup_phase;
   logic write_strobe;
   logic [31:0] next_rdata;
   logic [31:0] status_word;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------

   // Zero wait states: every access completes in its first cycle
   assign pready = 1'b1;
   assign setup_phase = psel & ~penable;
   assign write_strobe = psel & penable & pwrite;

   // One-cycle clear pulses from writing ones to the clear word
   always_comb begin
      clr_cut = '0;
      clr_simul = '0;
      if (write_strobe && paddr == CLEAR_OFS) begin
         clr_cut = pwdata[CLR_CUT_POS +: NUM_AXES];
         clr_simul = pwdata[CLR_SIMUL_POS +: NUM_AXES];
      end
   end

   // Report setting, reset to reporting on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         report_fault_setting <= REPORT_RST[NUM_AXES-1:0];
      end else if (write_strobe && paddr == CTRL_OFS) begin
         report_fault_setting <= pwdata[NUM_AXES-1:0];
      end
   end

   // Status word, one byte lane per axis
   always_comb begin
      status_word = '0;
      for (int i = 0; i < NUM_AXES; i++) begin
         status_word[i*STATUS_LANE +: STATUS_LANE] = {
            torque_enable[i], power_released[i],
            simultaneity_fault[i], cutoff_fault[i],
            cutoff_warning[i], cutoff_active[i],
            channel_b_status[i], channel_a_status[i]
         };
      end
   end

   // Read data mux
   always_comb begin
      next_rdata = '0;
      case (paddr)
         CTRL_OFS: begin
            next_rdata[NUM_AXES-1:0] = report_fault_setting;
         end
         STATUS_OFS: begin
            next_rdata = status_word;
         end
         CODE0_OFS: begin
            next_rdata = message_word(simultaneity_fault[0],
               cutoff_fault[0], cutoff_warning[0]);
         end
         CODE1_OFS: begin
            next_rdata = message_word(simultaneity_fault[1],
               cutoff_fault[1], cutoff_warning[1]);
         end
         default: begin
            next_rdata = '0;
         end
      endcase
   end

   // Answer captured in the setup cycle, shown in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= ~addr_mapped(paddr);
      end
   end

   // ----------------------------------------------------------------
   // Per-axis monitor
   // ----------------------------------------------------------------
   for (genvar ax = 0; ax < NUM_AXES; ax++) begin : g_axis
      logic ch_a;
      logic ch_b;
      logic en_s;
      logic cut;
      logic skew_trip;
      logic trip_set;
      logic hold_req;
      logic release_ok;
      logic rearm;
      logic [CNT_W-1:0] skew_cnt;
      logic warn_q;
      logic fault_q;
      logic simul_q;
      logic torque_q;
      logic cut_q;
      pwr_state_t state;
      pwr_state_t next_state;

      // Channel filters; test pulses up to the limit are ignored
      cutoff_input_filter #(
         .HOLD_CYC(PULSE_IGNORE_CYCLES)
      ) u_ch_a (
         .pclk(pclk),
         .presetn(presetn),
         .raw_in(cutoff_channel_a_input[ax]),
         .level(ch_a)
      );

      cutoff_input_filter #(
         .HOLD_CYC(PULSE_IGNORE_CYCLES)
      ) u_ch_b (
         .pclk(pclk),
         .presetn(presetn),
         .raw_in(cutoff_channel_b_input[ax]),
         .level(ch_b)
      );

      // Enable is synchronised only, no pulse filtering
      cutoff_input_filter #(
         .HOLD_CYC(0)
      ) u_en (
         .pclk(pclk),
         .presetn(presetn),
         .raw_in(axis_enable_input[ax]),
         .level(en_s)
      );

      // Cut-off whenever either channel is low
      assign cut = ~(ch_a & ch_b);

      // Channel skew timer; independent channel drive assumed
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            skew_cnt <= '0;
         end else if (ch_a == ch_b) begin
            skew_cnt <= '0;
         end else if (skew_cnt != CNT_W'(SIMUL_LIMIT_CYCLES)) begin
            skew_cnt <= skew_cnt + 1'b1;
         end
      end

      // Trip once the skew outlasts the limit, held while it lasts
      assign skew_trip = (ch_a != ch_b) &&
         (skew_cnt == CNT_W'(SIMUL_LIMIT_CYCLES));

      // Simultaneity fault: sticky, set wins, any report setting
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            simul_q <= 1'b0;
         end else if (skew_trip) begin
            simul_q <= 1'b1;
         end else if (clr_simul[ax]) begin
            simul_q <= 1'b0;
         end
      end

      // Cut-off fault on an enabled axis, gated by reporting
      assign trip_set = cut & en_s & report_fault_setting[ax];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fault_q <= 1'b0;
         end else if (trip_set) begin
            fault_q <= 1'b1;
         end else if (clr_cut[ax]) begin
            fault_q <= 1'b0;
         end
      end

      // Warning follows the cut-off on a disabled axis while reporting is on
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            warn_q <= 1'b0;
         end else begin
            warn_q <= cut & ~en_s & report_fault_setting[ax];
         end
      end

      // Axis must see enable low after a reported cut-off trip or any skew trip
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rearm <= 1'b0;
         end else if (trip_set || skew_trip) begin
            rearm <= 1'b1;
         end else if (state == PWR_REARM && !en_s) begin
            rearm <= 1'b0;
         end
      end

      // Release conditions of the power section
      assign hold_req = cut | simul_q;
      assign release_ok = ~cut & ~simul_q &
         (~report_fault_setting[ax] | ~fault_q);

      // Power section release sequence
      always_comb begin
         next_state = state;
         case (state)
            PWR_HOLD: begin
               if (release_ok) begin
                  next_state = rearm ? PWR_REARM : PWR_FREE;
               end
            end
            PWR_REARM: begin
               if (hold_req) begin
                  next_state = PWR_HOLD;
               end else if (!en_s) begin
                  next_state = PWR_FREE;
               end
            end
            PWR_FREE: begin
               if (hold_req) begin
                  next_state = PWR_HOLD;
               end
            end
            default: begin
               next_state = PWR_HOLD;
            end
         endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            state <= PWR_HOLD;
         end else begin
            state <= next_state;
         end
      end

      // Torque only with both channels, enable and a free section
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            torque_q <= 1'b0;
            cut_q <= 1'b1;
         end else begin
            torque_q <= (state == PWR_FREE) & en_s & ~cut &
               ~simul_q;
            cut_q <= cut;
         end
      end

      // Per-axis results onto the shared vectors
      assign channel_a_status[ax] = ch_a;
      assign channel_b_status[ax] = ch_b;
      assign cutoff_warning[ax] = warn_q;
      assign cutoff_fault[ax] = fault_q;
      assign simultaneity_fault[ax] = simul_q;
      assign torque_enable[ax] = torque_q;
      assign cutoff_active[ax] = cut_q;
      assign power_released[ax] = (state == PWR_FREE);
   end

endmodule

`default_nettype wire

// ===== verification/cutoff_mon_assertions.sv
// Port level checks of the torque cut-off monitor
`default_nettype none
module cutoff_mon_assertions
   import cutoff_mon_pkg::*;
#(
   parameter int PULSE_IGNORE_CYCLES = 8,
   parameter int SIMUL_LIMIT_CYCLES = 40
) (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Safety inputs and drive outputs
   input wire logic [NUM_AXES-1:0] cutoff_channel_a_input,
   input wire logic [NUM_AXES-1:0] cutoff_channel_b_input,
   input wire logic [NUM_AXES-1:0] axis_enable_input,
   input wire logic [NUM_AXES-1:0] torque_enable,
   input wire logic [NUM_AXES-1:0] power_released,
   input wire logic [NUM_AXES-1:0] cutoff_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int lo_a, lo_b, hi_ab, skew, lo_en;
   logic mapped;
   // Decode of the mapped words
   assign mapped = paddr inside {CTRL_OFS, STATUS_OFS, CLEAR_OFS,
                                 CODE0_OFS, CODE1_OFS};
   // Run lengths of the input levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_a <= 0;
         lo_b <= 0;
         hi_ab <= 0;
         skew <= 0;
         lo_en <= 0;
      end else begin
         lo_a <= cutoff_channel_a_input[0] ? 0 : lo_a + 1;
         lo_b <= cutoff_channel_b_input[0] ? 0 : lo_b + 1;
         hi_ab <= (cutoff_channel_a_input[0] & cutoff_channel_b_input[0]) ?
                  hi_ab + 1 : 0;
         skew <= (cutoff_channel_a_input[1] ^ cutoff_channel_b_input[1]) ?
                 skew + 1 : 0;
         lo_en <= axis_enable_input[0] ? 0 : lo_en + 1;
      end
   end
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_bad_access;
      s_access ##0 !mapped;
   endsequence
   property p_ready;
      psel |-> pready;
   endproperty
   property p_slverr;
      s_access |-> pslverr == !mapped;
   endproperty
   property p_bad_zero;
      s_bad_access |-> prdata == 32'h0;
   endproperty
   property p_torque_gate;
      torque_enable[0] |-> !cutoff_active[0] && power_released[0];
   endproperty
   property p_enable_gate;
      lo_en == 6 |-> !torque_enable[0];
   endproperty
   property p_cut_assert;
      lo_a == PULSE_IGNORE_CYCLES + 6 |->
         cutoff_active[0] && !torque_enable[0];
   endproperty
   property p_pulse_ignore;
      $rose(cutoff_active[0]) |->
         lo_a >= PULSE_IGNORE_CYCLES || lo_b >= PULSE_IGNORE_CYCLES;
   endproperty
   property p_release;
      hi_ab == 6 |-> !cutoff_active[0];
   endproperty
   property p_simul_hold;
      skew == SIMUL_LIMIT_CYCLES + PULSE_IGNORE_CYCLES + 8 |=>
         (!power_released[1] && !torque_enable[1])[*8];
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready low in a transfer");
   a_slverr: assert property (p_slverr)
      else $error("pslverr wrong for address");
   a_bad_zero: assert property (p_bad_zero)
      else $error("unmapped read not zero");
   a_torque_gate: assert property (p_torque_gate)
      else $error("torque without release");
   a_enable_gate: assert property (p_enable_gate)
      else $error("torque while disabled");
   a_cut_assert: assert property (p_cut_assert)
      else $error("cut-off late");
   a_pulse_ignore: assert property (p_pulse_ignore)
      else $error("short pulse caused cut-off");
   a_release: assert property (p_release)
      else $error("cut-off release late");
   a_simul_hold: assert property (p_simul_hold)
      else $error("skewed axis not held safe");
endmodule
`default_nettype wire

// ===== verification/safety_ctrl_model.sv
// Behavioural safety controller with two switching outputs per axis
`default_nettype none
module safety_ctrl_model
   import cutoff_mon_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Requested levels
   input wire logic [NUM_AXES-1:0] want_a,
   input wire logic [NUM_AXES-1:0] want_b,
   // Separate outputs, 24 V present at start
   output var logic [NUM_AXES-1:0] chan_a = '1,
   output var logic [NUM_AXES-1:0] chan_b = '1
);
   timeunit 1ns;
   timeprecision 1ps;
   // Channel A switched on its own
   always_ff @(posedge pclk) chan_a <= want_a;
   // Channel B switched on its own
   always_ff @(posedge pclk) chan_b <= want_b;
endmodule
`default_nettype wire

// ===== verification/tb_torque_cutoff_monitor.sv
// Self-checking bench of the torque cut-off monitor
`default_nettype none
module tb_torque_cutoff_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   import cutoff_mon_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NUM_AXES-1:0] ch_a, ch_b, want_a, want_b, en, trq, pwr, cut;
   logic [5:0] outs;
   int error_cnt, n_compared;
   assign outs = {cut, pwr, trq};
   safety_ctrl_model u_ctrl (.pclk(pclk), .want_a(want_a),
      .want_b(want_b), .chan_a(ch_a), .chan_b(ch_b));
   torque_cutoff_monitor #(.PULSE_IGNORE_CYCLES(8),
      .SIMUL_LIMIT_CYCLES(40)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cutoff_channel_a_input(ch_a),
      .cutoff_channel_b_input(ch_b), .axis_enable_input(en),
      .torque_enable(trq), .power_released(pwr), .cutoff_active(cut));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic drive(input int ax, input logic a, input logic b,
                        input int n);
      @(posedge pclk);
      want_a[ax] <= a;
      want_b[ax] <= b;
      wt(n);
   endtask
   task automatic set_en(input int ax, input logic v);
      @(posedge pclk);
      en[ax] <= v;
      wt(10);
   endtask
   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      #160000;
      error_cnt++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, en} = '0;
      want_a = '1;
      want_b = '1;
      error_cnt = 0;
      n_compared = 0;
      wt(3);
      presetn <= 1'b1;
      wt(10);
      rchk(CTRL_OFS, 32'h3);
      rchk(8'h20, 32'h0);
      chk(32'(er), 32'h1);
      rchk(STATUS_OFS, 32'h4343);
      drive(0, 1'b0, 1'b1, 3);
      rchk(STATUS_OFS, 32'h4343);
      drive(0, 1'b1, 1'b1, 10);
      rchk(STATUS_OFS, 32'h4343);
      $display("Test reset and pulse done");
      set_en(0, 1'b1);
      chk(32'(outs), 32'h0D);
      drive(0, 1'b0, 1'b0, 20);
      chk(32'(outs), 32'h18);
      rchk(STATUS_OFS, 32'h4314);
      rchk(CODE0_OFS, 32'h0002_9000);
      drive(0, 1'b1, 1'b1, 10);
      chk(32'(outs), 32'h08);
      apb(1'b1, CLEAR_OFS, 32'h1);
      wt(10);
      chk(32'(outs), 32'h08);
      set_en(0, 1'b0);
      chk(32'(outs), 32'h0C);
      set_en(0, 1'b1);
      chk(32'(outs), 32'h0D);
      $display("Test enabled trip done");
      set_en(0, 1'b0);
      drive(0, 1'b0, 1'b0, 20);
      rchk(STATUS_OFS, 32'h430C);
      rchk(CODE0_OFS, 32'h0003_9000);
      drive(0, 1'b1, 1'b1, 10);
      chk(32'(outs), 32'h0C);
      $display("Test disabled trip done");
      apb(1'b1, CTRL_OFS, 32'h2);
      rchk(CTRL_OFS, 32'h2);
      set_en(0, 1'b1);
      drive(0, 1'b0, 1'b0, 20);
      rchk(STATUS_OFS, 32'h4304);
      drive(0, 1'b1, 1'b1, 10);
      chk(32'(outs), 32'h0D);
      apb(1'b1, CTRL_OFS, 32'h3);
      set_en(0, 1'b0);
      $display("Test report off done");
      set_en(1, 1'b1);
      drive(1, 1'b1, 1'b0, 70);
      chk(32'(outs), 32'h24);
      rchk(STATUS_OFS, 32'h3543);
      apb(1'b1, CLEAR_OFS, 32'h202);
      rchk(CODE1_OFS, 32'h0002_9005);
      drive(1, 1'b1, 1'b1, 10);
      chk(32'(outs), 32'h04);
      apb(1'b1, CLEAR_OFS, 32'h202);
      set_en(1, 1'b0);
      chk(32'(outs), 32'h0C);
      set_en(1, 1'b1);
      chk(32'(outs), 32'h0E);
      $display("Test simultaneity done");
      tally_and_finish;
   end
endmodule
bind torque_cutoff_monitor cutoff_mon_assertions #(
   .PULSE_IGNORE_CYCLES(PULSE_IGNORE_CYCLES),
   .SIMUL_LIMIT_CYCLES(SIMUL_LIMIT_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cutoff_channel_a_input(cutoff_channel_a_input),
   .cutoff_channel_b_input(cutoff_channel_b_input),
   .axis_enable_input(axis_enable_input), .torque_enable(torque_enable),
   .power_released(power_released), .cutoff_active(cutoff_active));
`default_nettype wire
